// File: design/comf_mode_fsm.sv
// Operating-mode state machine of the safety network controller
`timescale 1ns/100ps
`default_nettype none
module comf_mode_fsm
	import comf_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     rst_in,
	// Internal checks
	input  wire logic                     diag_pass_in,
	input  wire logic                     id_set_in,
	input  wire logic                     config_valid_in,
	input  wire logic                     config_error_in,
	input  wire logic                     switch_changed_in,
	input  wire logic                     critical_error_in,
	// Tool commands, one-cycle pulses
	input  wire logic                     config_done_in,
	input  wire logic                     cmd_run_in,
	input  wire logic                     cmd_idle_in,
	input  wire logic                     password_ok_in,
	// Mode and functions
	output comf_mode_type                 mode_out,
	output comf_func_type                 func_out,
	output logic [COMF_STATUS_W-1:0]      status_word_out,
	// Module status indicator lamps
	output logic                          led_green_out,
	output logic                          led_red_out
);
	comf_mode_type                mode;
	comf_mode_type                next_mode;
	logic [COMF_DIAG_CNT_W-1:0]   diag_cnt;
	logic [COMF_DIAG_CNT_W-1:0]   next_diag_cnt;
	logic [COMF_FLASH_W-1:0]      flash_cnt;
	logic [COMF_FLASH_W-1:0]      next_flash_cnt;
	logic                         phase;
	logic                         next_phase;
	comf_func_type                next_func;
	logic [COMF_STATUS_W-1:0]     next_status;
	comf_led_type                 led_pattern;

	// ======================================================
	// Mode transitions
	// Critical error outranks everything; critical traps until reset, abort leaves only for critical
	always_comb begin
		next_mode     = mode;
		next_diag_cnt = diag_cnt;
		unique case (mode)
			COMF_SELF_DIAG: begin
				// Minimum dwell keeps diagnosis from being skipped
				if (diag_cnt != COMF_DIAG_CYCLES)
					next_diag_cnt = diag_cnt + 1'b1;
				else if (diag_pass_in)
					next_mode = COMF_WAIT_ID;
			end
			COMF_WAIT_ID: begin
				if (id_set_in && config_valid_in && !config_error_in)
					next_mode = COMF_IDLE;
				else if (id_set_in)
					next_mode = COMF_CONFIGURING;
			end
			COMF_CONFIGURING: begin
				if (config_done_in)
					next_mode = COMF_IDLE;
			end
			COMF_IDLE: begin
				if (config_error_in)
					next_mode = COMF_CONFIGURING;
				else if (switch_changed_in)
					next_mode = COMF_ABORT;
				else if (cmd_run_in && password_ok_in)
					next_mode = COMF_RUN;
			end
			COMF_RUN: begin
				if (config_error_in)
					next_mode = COMF_CONFIGURING;
				else if (switch_changed_in)
					next_mode = COMF_ABORT;
				else if (cmd_idle_in && password_ok_in)
					next_mode = COMF_IDLE;
			end
			COMF_ABORT:    next_mode = COMF_ABORT;
			COMF_CRITICAL: next_mode = COMF_CRITICAL;
			default:       next_mode = COMF_CRITICAL;
		endcase
		if (critical_error_in)
			next_mode = COMF_CRITICAL;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode     <= COMF_SELF_DIAG;
			diag_cnt <= '0;
		end else begin
			mode     <= next_mode;
			diag_cnt <= next_diag_cnt;
		end
	end

	// ======================================================
	// Function permissions, status word, indicator pattern
	// Computed from next mode so outputs track mode without lag
	always_comb begin
		next_func   = '0;
		next_status = '0;
		led_pattern = COMF_LED_ALTERNATE;
		next_func.outputs_safe = 1'b1;
		unique case (next_mode)
			COMF_RUN: begin
				next_func.user_program   = 1'b1;
				next_func.safety_io      = 1'b1;
				next_func.safety_refresh = 1'b1;
				next_func.standard_io    = 1'b1;
				next_func.message        = 1'b1;
				next_func.outputs_safe   = 1'b0;
				next_status[COMF_RUN_FLAG_BIT] = 1'b1;
				led_pattern = COMF_LED_GREEN;
			end
			COMF_IDLE: begin
				next_func.standard_io = 1'b1;
				next_func.message     = 1'b1;
				led_pattern = COMF_LED_GREEN_FLASH;
			end
			COMF_CONFIGURING: begin
				next_func.message = 1'b1;
				led_pattern = COMF_LED_ALTERNATE;
			end
			COMF_ABORT: begin
				next_func.message = 1'b1;
				led_pattern = COMF_LED_RED_FLASH;
			end
			COMF_CRITICAL: begin
				next_func.message = 1'b0;
				led_pattern = COMF_LED_RED;
			end
			default: led_pattern = COMF_LED_ALTERNATE;
		endcase
	end

	// ======================================================
	// Flash timebase, free-running so phases stay even
	always_comb begin
		next_flash_cnt = flash_cnt + 1'b1;
		next_phase     = phase;
		if (flash_cnt == COMF_FLASH_LAST) begin
			next_flash_cnt = '0;
			next_phase     = ~phase;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flash_cnt       <= '0;
			phase           <= 1'b0;
			mode_out        <= COMF_SELF_DIAG;
			func_out        <= '{outputs_safe: 1'b1, default: 1'b0};
			status_word_out <= '0;
		end else begin
			flash_cnt       <= next_flash_cnt;
			phase           <= next_phase;
			mode_out        <= next_mode;
			func_out        <= next_func;
			status_word_out <= next_status;
		end
	end

	// ======================================================
	// Lamp drive
	comf_led_driver u_led (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.pattern_in (led_pattern),
		.phase_in   (phase),
		.green_out  (led_green_out),
		.red_out    (led_red_out)
	);
endmodule // comf_mode_fsm
`default_nettype wire

// File: design/comf_pkg.sv
// Package for the controller operating-mode state machine
package comf_pkg;
	// ======================================================
	// Modes
	typedef enum logic [2:0] {
		COMF_SELF_DIAG,
		COMF_WAIT_ID,
		COMF_CONFIGURING,
		COMF_IDLE,
		COMF_RUN,
		COMF_ABORT,
		COMF_CRITICAL
	} comf_mode_type;

	// ======================================================
	// Indicator patterns
	typedef enum logic [2:0] {
		COMF_LED_OFF,
		COMF_LED_GREEN,
		COMF_LED_GREEN_FLASH,
		COMF_LED_RED,
		COMF_LED_RED_FLASH,
		COMF_LED_ALTERNATE
	} comf_led_type;

	// ======================================================
	// Permitted functions
	typedef struct packed {
		logic user_program;
		logic safety_io;
		logic safety_refresh;
		logic standard_io;
		logic message;
		logic outputs_safe;
	} comf_func_type;

	// ======================================================
	// Constants
	localparam int COMF_STATUS_W       = 16;
	localparam int COMF_RUN_FLAG_BIT   = 6;
	localparam int COMF_DIAG_CNT_W     = 4;
	localparam logic [3:0] COMF_DIAG_CYCLES = 4'hf;
	localparam int COMF_FLASH_W        = 8;
	localparam int COMF_FLASH_PERIOD   = 64;
	localparam logic [7:0] COMF_FLASH_LAST =
		8'(COMF_FLASH_PERIOD - 1);
endpackage

// File: design/comf_led_driver.sv
// Indicator pattern to green and red lamp drive
`timescale 1ns/100ps
`default_nettype none
module comf_led_driver
	import comf_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// Pattern and phase
	input  wire comf_led_type pattern_in,
	input  wire logic         phase_in,
	// Lamps
	output logic              green_out,
	output logic              red_out
);
	logic next_green;
	logic next_red;

	// ======================================================
	// Decode pattern
	always_comb begin
		next_green = 1'b0;
		next_red   = 1'b0;
		unique case (pattern_in)
			COMF_LED_OFF:         next_green = 1'b0;
			COMF_LED_GREEN:       next_green = 1'b1;
			COMF_LED_GREEN_FLASH: next_green = phase_in;
			COMF_LED_RED:         next_red   = 1'b1;
			COMF_LED_RED_FLASH:   next_red   = phase_in;
			COMF_LED_ALTERNATE: begin
				next_green = phase_in;
				next_red   = ~phase_in;
			end
			default: begin
				next_green = 1'b0;
				next_red   = 1'b0;
			end
		endcase
	end

	// Register the lamps
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			green_out <= 1'b0;
			red_out   <= 1'b0;
		end else begin
			green_out <= next_green;
			red_out   <= next_red;
		end
	end
endmodule // comf_led_driver
`default_nettype wire

// File: tb/comf_tool_model.sv
// Configuration tool model issuing one-cycle command pulses
`timescale 1ns/100ps
`default_nettype none
module comf_tool_model (
	// Clock and bench requests {done, run, idle}
	input	wire logic	clk_in,
	input	wire logic [2:0]	req_in,
	input	wire logic	bad_pw_in,
	// Pulses toward the controller
	output	var logic	done_out = 1'b0,
	output	var logic	run_out = 1'b0,
	output	var logic	idle_out = 1'b0,
	output	var logic	pw_out = 1'b0
);
	// ==========================================
	// Launch
	// Password rides only with a mode command, so a stray one never helps
	always @(posedge clk_in) begin
		{done_out, run_out, idle_out} <= req_in;
		pw_out <= |req_in[1:0] && !bad_pw_in;
	end
endmodule // comf_tool_model
`default_nettype wire

// File: tb/comf_mode_fsm_properties.sv
// Concurrent checks on the operating-mode state machine ports
`timescale 1ns/100ps
`default_nettype none
module comf_mode_fsm_properties
	import comf_pkg::*;
(
	// Clock, reset and causes
	input	wire logic	clk_in,
	input	wire logic	rst_in,
	input	wire logic	config_error_in,
	input	wire logic	switch_changed_in,
	input	wire logic	critical_error_in,
	input	wire logic	cmd_run_in,
	input	wire logic	password_ok_in,
	// Observed outputs
	input	wire comf_mode_type	mode_out,
	input	wire comf_func_type	func_out,
	input	wire logic [15:0]	status_word_out,
	input	wire logic	led_green_out,
	input	wire logic	led_red_out
);
	// ==========================================
	// Properties
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Lamps change on the same edge as the mode
	sequence s_run_held;
		mode_out == COMF_RUN [*2];
	endsequence
	a_run_flag_bit: assert property (status_word_out ==
		{9'h0, mode_out == COMF_RUN, 6'h0}) else $error("run flag wrong");
	a_crit_entry: assert property (critical_error_in |=>
		mode_out == COMF_CRITICAL) else $error("no critical entry");
	a_crit_funcs: assert property (mode_out == COMF_CRITICAL |->
		func_out == 6'h01) else $error("critical functions live");
	a_abort_funcs: assert property (mode_out == COMF_ABORT |->
		func_out == 6'h03) else $error("abort functions wrong");
	a_abort_kept: assert property (mode_out == COMF_ABORT |=>
		mode_out inside {COMF_ABORT, COMF_CRITICAL}) else $error("left abort");
	a_crit_kept: assert property (mode_out == COMF_CRITICAL |=>
		$stable(mode_out)) else $error("left critical");
	a_switch_abort: assert property (!config_error_in &&
		!critical_error_in && switch_changed_in &&
		mode_out inside {COMF_IDLE, COMF_RUN} |=> mode_out == COMF_ABORT)
		else $error("switch change missed");
	a_cmd_run: assert property (mode_out == COMF_IDLE && cmd_run_in &&
		password_ok_in && !config_error_in && !switch_changed_in &&
		!critical_error_in |=> mode_out == COMF_RUN) else $error("no run");
	a_run_lamp: assert property (s_run_held |->
		led_green_out && !led_red_out) else $error("run lamp wrong");
endmodule // comf_mode_fsm_properties
bind comf_mode_fsm comf_mode_fsm_properties u_props (
	.clk_in(clk_in), .rst_in(rst_in), .config_error_in(config_error_in),
	.switch_changed_in(switch_changed_in), .cmd_run_in(cmd_run_in),
	.critical_error_in(critical_error_in), .password_ok_in(password_ok_in),
	.mode_out(mode_out), .func_out(func_out), .led_red_out(led_red_out),
	.status_word_out(status_word_out), .led_green_out(led_green_out));
`default_nettype wire

// File: tb/tb_comf_mode_fsm.sv
// Random-stimulus bench with a reference model for the mode machine
`timescale 1ns/100ps
`default_nettype none
module tb_comf_mode_fsm
	import comf_pkg::*;
;
	// ==========================================
	// Signals
	logic clk_in = 1'b0, rst_in = 1'b1, diag_pass = 1'b0, id_set = 1'b0;
	logic cfg_valid = 1'b0, cfg_err = 1'b0, sw_chg = 1'b0, crit = 1'b0;
	logic bad_pw = 1'b0, done, run, idle, pw, green, red;
	logic [2:0] req = 3'h0;
	logic [15:0] status;
	comf_mode_type mode;
	comf_func_type func;
	int bad_count = 0, total_checks = 0, cyc = 0, m = 0, pm = 0;
	bit trk = 0;
	always #2 clk_in = ~clk_in;
	comf_tool_model tool (.clk_in(clk_in), .req_in(req), .bad_pw_in(bad_pw),
		.done_out(done), .run_out(run), .idle_out(idle), .pw_out(pw));
	comf_mode_fsm dut (.clk_in(clk_in), .rst_in(rst_in),
		.diag_pass_in(diag_pass), .id_set_in(id_set),
		.config_valid_in(cfg_valid), .config_error_in(cfg_err),
		.switch_changed_in(sw_chg), .critical_error_in(crit),
		.config_done_in(done), .cmd_run_in(run), .cmd_idle_in(idle),
		.password_ok_in(pw), .mode_out(mode), .func_out(func),
		.status_word_out(status), .led_green_out(green), .led_red_out(red));
	// ==========================================
	// Reference model
	function automatic int nxt(input int s);
		if (crit) return COMF_CRITICAL;
		case (s)
			COMF_WAIT_ID: if (id_set) return (cfg_valid && !cfg_err) ?
				COMF_IDLE : COMF_CONFIGURING;
			COMF_CONFIGURING: if (done) return COMF_IDLE;
			COMF_IDLE, COMF_RUN: begin
				if (cfg_err) return COMF_CONFIGURING;
				if (sw_chg) return COMF_ABORT;
				if (pw && run && s == COMF_IDLE) return COMF_RUN;
				if (pw && idle && s == COMF_RUN) return COMF_IDLE;
			end
			default: ;
		endcase
		return s;
	endfunction
	function automatic logic [15:0] fexp(input int s);
		case (s)
			COMF_RUN: return 16'h3e;
			COMF_IDLE: return 16'h07;
			COMF_CONFIGURING, COMF_ABORT: return 16'h03;
			default: return 16'h01;
		endcase
	endfunction
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (bad_count == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Model steps on the same inputs the design samples at each edge
	always @(posedge clk_in) begin
		pm = m;
		if (trk) m = nxt(m);
		cyc++;
		if (cyc == 12000) begin
			bad_count++;
			complete_run();
		end
	end
	// Outputs are settled by the falling edge
	always @(negedge clk_in) begin
		if (trk) begin
			cmp(16'(mode), 16'(m));
			cmp(status, {9'h0, m == COMF_RUN, 6'h0});
			if (m != COMF_WAIT_ID) cmp(16'(func), fexp(m));
			if (m == pm && (m == COMF_RUN || m == COMF_CRITICAL))
				cmp(16'({green, red}), m == COMF_RUN ? 16'h2 : 16'h1);
		end
	end
	// ==========================================
	// Main sequence: reset, diagnosis dwell, then random traffic
	initial begin
		int n;
		void'($urandom(32'hc1e4));
		for (int r = 0; r < 12; r++) begin
			@(posedge clk_in);
			trk = 0;
			rst_in <= 1'b1;
			{id_set, cfg_err, sw_chg, crit, req} <= 7'h0;
			diag_pass <= r[0];
			repeat (4) @(posedge clk_in);
			rst_in <= 1'b0;
			n = 0;
			while (mode !== COMF_WAIT_ID && n < 60) begin
				@(posedge clk_in);
				if (n == 20) diag_pass <= 1'b1;
				n++;
				@(negedge clk_in);
			end
			cmp(16'(n >= (r[0] ? 16 : 22)), 16'h1);
			m = COMF_WAIT_ID;
			trk = 1;
			for (int k = 0; k < 700; k++) begin
				@(posedge clk_in);
				id_set <= ($urandom % 10) == 0;
				cfg_valid <= ($urandom % 4) != 0;
				cfg_err <= ($urandom % 60) == 0;
				sw_chg <= ($urandom % 200) == 0;
				crit <= ($urandom % 400) == 0;
				req <= ($urandom % 3) == 0 ? 3'($urandom) : 3'h0;
				bad_pw <= ($urandom % 5) == 0;
			end
		end
		complete_run();
	end
endmodule // tb_comf_mode_fsm
`default_nettype wire
